// ===== rtl/input_port_interrupt_unit.sv
// Input port block with two interrupt groups, regulation inputs and an APB register file.
`timescale 1ns/100ps
module input_port_interrupt_unit #(
  parameter int FAST_HALF = input_port_pkg::FAST_HALF_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] group_a_input_pins,
  input wire logic [3:0] group_b_input_pins,
  input wire logic [3:0] regulation_input_pins,
  input wire logic regulation_extra_pin,
  input wire logic limiter_level_status,
  output logic recharge_monitor_out_enable,
  output logic limiter_monitor_out_enable,
  output logic irq
);

  // Every piece of state of the block outside the synchroniser and divider, registered as one word.
  typedef struct packed {
    logic [3:0] a_sel;      // Group A interrupt select.
    logic [3:0] a_cmp;      // Group A edge compare.
    logic [3:0] b_sel;      // Group B interrupt select.
    logic [3:0] b_rate;     // Group B sample rate select.
    logic [3:0] b_en;       // Group B sample enable.
    logic a_mask;           // Group A mask, 1 lets the request through.
    logic b_mask;           // Group B mask.
    logic a_flag;           // Group A factor flag.
    logic b_flag;           // Group B factor flag.
    logic mon_recharge;     // Recharge monitor output enable.
    logic mon_limiter;      // Limiter monitor output enable.
    logic a_match;          // Group A compare result of the previous cycle.
    logic [3:0] b_samp;     // Group B sampled levels.
    logic [3:0] b_gate;     // Selected raw level of group B, for rising-edge detection.
    logic [3:0] rdata;      // Read data captured in the setup cycle.
    logic rerr;             // Unmapped address seen in the setup cycle.
  } unit_s;

  unit_s st;
  unit_s next_st;

  // Synchronised view of all pins, bundled so one synchroniser serves them all.
  logic [input_port_pkg::PIN_BUNDLE_W-1:0] pins_sync;
  logic [3:0] a_pin;
  logic [3:0] b_pin;
  logic [3:0] reg_pin;
  logic extra_pin;
  logic limit_pin;

  // Sampling clock edges and the per-pin choice between them.
  logic fast_rise;
  logic slow_rise;
  logic [3:0] b_tick;

  // Decoded bus signals.
  logic [15:0] idx;
  logic hit;
  logic setup;
  logic wr;

  // Events of this cycle.
  logic a_match_now;
  logic a_event;
  logic b_event;

  // Read-side views.
  logic [3:0] b_data;
  logic [3:0] read_val;

  // All pins pass the three-stage synchroniser before any logic looks at them.
  pin_sync3 #(
    .W(input_port_pkg::PIN_BUNDLE_W)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pins_async({limiter_level_status, regulation_extra_pin, regulation_input_pins,
                 group_b_input_pins, group_a_input_pins}),
    .pins_sync(pins_sync)
  );

  assign a_pin = pins_sync[3:0];
  assign b_pin = pins_sync[7:4];
  assign reg_pin = pins_sync[11:8];
  assign extra_pin = pins_sync[12];
  assign limit_pin = pins_sync[13];

  // Shared 256 Hz and 32 Hz sampling clock source.
  sample_clock_gen #(
    .FAST_HALF(FAST_HALF)
  ) u_clk (
    .pclk(pclk),
    .presetn(presetn),
    .fast_rise(fast_rise),
    .slow_rise(slow_rise)
  );

  // Each group B pin picks its own sampling clock.
  for (genvar i = 0; i < 4; i++) begin : g_tick
    assign b_tick[i] = st.b_rate[i] ? fast_rise : slow_rise;
  end

  // Address decode: word aligned, index in the upper bits.
  assign idx = paddr[17:2];
  assign setup = psel && !penable;
  // Zero wait states: every access completes in its first access cycle.
  assign pready = 1'b1;
  assign pslverr = psel && penable && st.rerr;
  assign wr = psel && penable && pwrite && !st.rerr;

  // Known index decode; misaligned addresses count as unmapped.
  always_comb begin
    hit = 1'b0;
    if (paddr[1:0] == 2'b00) begin
      unique case (idx)
        input_port_pkg::IDX_GROUP_A_IRQ_SELECT,
        input_port_pkg::IDX_GROUP_A_INPUT_DATA,
        input_port_pkg::IDX_GROUP_A_EDGE_COMPARE,
        input_port_pkg::IDX_GROUP_B_IRQ_SELECT,
        input_port_pkg::IDX_GROUP_B_INPUT_DATA,
        input_port_pkg::IDX_REGULATION_INPUT_NIBBLE,
        input_port_pkg::IDX_MONITOR_ENABLES_AND_REGULATION_BIT,
        input_port_pkg::IDX_GROUP_B_SAMPLE_RATE_SELECT,
        input_port_pkg::IDX_GROUP_B_SAMPLE_ENABLE,
        input_port_pkg::IDX_GROUP_A_IRQ_MASK_REG,
        input_port_pkg::IDX_GROUP_B_IRQ_MASK_REG,
        input_port_pkg::IDX_GROUP_A_IRQ_FLAG_REG,
        input_port_pkg::IDX_GROUP_B_IRQ_FLAG_REG: hit = 1'b1;
        default: hit = 1'b0;
      endcase
    end
  end

  // Group B read data shows the sampled level where the sampler runs.
  assign b_data = (st.b_en & st.b_samp) | (~st.b_en & b_pin);

  // Read multiplexer; unused bits and unmapped indices read as zero.
  always_comb begin
    read_val = 4'h0;
    unique case (idx)
      input_port_pkg::IDX_GROUP_A_IRQ_SELECT: read_val = st.a_sel;
      input_port_pkg::IDX_GROUP_A_INPUT_DATA: read_val = a_pin;
      input_port_pkg::IDX_GROUP_A_EDGE_COMPARE: read_val = st.a_cmp;
      input_port_pkg::IDX_GROUP_B_IRQ_SELECT: read_val = st.b_sel;
      input_port_pkg::IDX_GROUP_B_INPUT_DATA: read_val = b_data;
      input_port_pkg::IDX_REGULATION_INPUT_NIBBLE: read_val = reg_pin;
      input_port_pkg::IDX_MONITOR_ENABLES_AND_REGULATION_BIT: begin
        read_val[input_port_pkg::MON_BIT_RECHARGE_ENABLE] = st.mon_recharge;
        read_val[input_port_pkg::MON_BIT_LIMITER_ENABLE] = st.mon_limiter;
        read_val[input_port_pkg::MON_BIT_LIMITER_STATUS] = limit_pin;
        read_val[input_port_pkg::MON_BIT_REGULATION_EXTRA] = extra_pin;
      end
      input_port_pkg::IDX_GROUP_B_SAMPLE_RATE_SELECT: read_val = st.b_rate;
      input_port_pkg::IDX_GROUP_B_SAMPLE_ENABLE: read_val = st.b_en;
      input_port_pkg::IDX_GROUP_A_IRQ_MASK_REG: read_val[input_port_pkg::MASK_FLAG_BIT] = st.a_mask;
      input_port_pkg::IDX_GROUP_B_IRQ_MASK_REG: read_val[input_port_pkg::MASK_FLAG_BIT] = st.b_mask;
      input_port_pkg::IDX_GROUP_A_IRQ_FLAG_REG: read_val[input_port_pkg::MASK_FLAG_BIT] = st.a_flag;
      input_port_pkg::IDX_GROUP_B_IRQ_FLAG_REG: read_val[input_port_pkg::MASK_FLAG_BIT] = st.b_flag;
      default: read_val = 4'h0;
    endcase
  end

  // Group A matches when every selected pin equals its compare bit; deselected pins always match.
  // A compare bit of 1 therefore matches a high pin and fires on the fall, 0 fires on the rise.
  assign a_match_now = &(~st.a_sel | ~(a_pin ^ st.a_cmp));
  // Only a move from match to mismatch counts; mismatch to mismatch does not.
  // Clearing a select bit forces a match, so setting it again at the active level fires once more.
  assign a_event = st.a_match && !a_match_now;

  // Next-state logic for the whole block.
  always_comb begin
    next_st = st;
    b_event = 1'b0;

    // Group A compare history.
    next_st.a_match = a_match_now;

    // Group B: samplers and per-pin edge detection.
    for (int i = 0; i < 4; i++) begin
      if (st.b_en[i]) begin
        // The sampler updates only on its chosen clock's rising edge.
        if (b_tick[i]) begin
          if (st.b_sel[i] && (b_pin[i] != st.b_samp[i])) begin
            b_event = 1'b1;
          end
          next_st.b_samp[i] = b_pin[i];
        end
      end else begin
        // The sampler tracks the pin while off, so turning it on gives no false change.
        next_st.b_samp[i] = b_pin[i];
        // Unsampled upper pins fire on the rise of their selected level; lower pins stay silent.
        if (i >= 2 && st.b_sel[i] && b_pin[i] && !st.b_gate[i]) begin
          b_event = 1'b1;
        end
      end
      next_st.b_gate[i] = st.b_sel[i] & b_pin[i];
    end

    // Capture read data and the decode result in the setup cycle, so both come from flops.
    if (setup) begin
      next_st.rdata = pwrite ? 4'h0 : read_val;
      next_st.rerr = !hit;
    end

    // Register writes take effect at the access edge; read-only bits ignore them.
    if (wr) begin
      unique case (idx)
        input_port_pkg::IDX_GROUP_A_IRQ_SELECT: next_st.a_sel = pwdata[3:0];
        input_port_pkg::IDX_GROUP_A_EDGE_COMPARE: next_st.a_cmp = pwdata[3:0];
        input_port_pkg::IDX_GROUP_B_IRQ_SELECT: next_st.b_sel = pwdata[3:0];
        input_port_pkg::IDX_MONITOR_ENABLES_AND_REGULATION_BIT: begin
          next_st.mon_recharge = pwdata[input_port_pkg::MON_BIT_RECHARGE_ENABLE];
          next_st.mon_limiter = pwdata[input_port_pkg::MON_BIT_LIMITER_ENABLE];
        end
        input_port_pkg::IDX_GROUP_B_SAMPLE_RATE_SELECT: next_st.b_rate = pwdata[3:0];
        input_port_pkg::IDX_GROUP_B_SAMPLE_ENABLE: next_st.b_en = pwdata[3:0];
        input_port_pkg::IDX_GROUP_A_IRQ_MASK_REG: next_st.a_mask = pwdata[input_port_pkg::MASK_FLAG_BIT];
        input_port_pkg::IDX_GROUP_B_IRQ_MASK_REG: next_st.b_mask = pwdata[input_port_pkg::MASK_FLAG_BIT];
        input_port_pkg::IDX_GROUP_A_IRQ_FLAG_REG: begin
          // Writing one clears, writing zero leaves the flag alone.
          if (pwdata[input_port_pkg::MASK_FLAG_BIT]) begin
            next_st.a_flag = 1'b0;
          end
        end
        input_port_pkg::IDX_GROUP_B_IRQ_FLAG_REG: begin
          if (pwdata[input_port_pkg::MASK_FLAG_BIT]) begin
            next_st.b_flag = 1'b0;
          end
        end
        default: begin
          // Read-only and data registers keep their value.
        end
      endcase
    end

    // Events set the flags whatever the mask says, and win over a clear in the same cycle.
    if (a_event) begin
      next_st.a_flag = 1'b1;
    end
    if (b_event) begin
      next_st.b_flag = 1'b1;
    end
  end

  // Register the block state; everything clears at reset except a_match, which starts at 1.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.a_sel <= input_port_pkg::RESET_NIBBLE;
      st.a_cmp <= input_port_pkg::RESET_NIBBLE;
      st.b_sel <= input_port_pkg::RESET_NIBBLE;
      st.b_rate <= input_port_pkg::RESET_NIBBLE;
      st.b_en <= input_port_pkg::RESET_NIBBLE;
      st.a_mask <= input_port_pkg::RESET_BIT;
      st.b_mask <= input_port_pkg::RESET_BIT;
      st.a_flag <= input_port_pkg::RESET_BIT;
      st.b_flag <= input_port_pkg::RESET_BIT;
      st.a_match <= input_port_pkg::RESET_GROUP_A_MATCH;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state word.
  assign prdata = {28'h0000000, st.rdata};
  assign recharge_monitor_out_enable = st.mon_recharge;
  assign limiter_monitor_out_enable = st.mon_limiter;
  // A flag keeps the request up until software clears it, so the service routine must clear it first.
  assign irq = (st.a_flag && st.a_mask) || (st.b_flag && st.b_mask);

endmodule : input_port_interrupt_unit

// ===== rtl/input_port_pkg.sv
// Shared constants for the input port interrupt unit: register indices, reset values and timing.
package input_port_pkg;

  // Register indices as printed; the APB byte address is four times the index.
  localparam logic [15:0] IDX_GROUP_A_IRQ_SELECT = 16'hFF20;
  localparam logic [15:0] IDX_GROUP_A_INPUT_DATA = 16'hFF21;
  localparam logic [15:0] IDX_GROUP_A_EDGE_COMPARE = 16'hFF22;
  localparam logic [15:0] IDX_GROUP_B_IRQ_SELECT = 16'hFF24;
  localparam logic [15:0] IDX_GROUP_B_INPUT_DATA = 16'hFF25;
  localparam logic [15:0] IDX_REGULATION_INPUT_NIBBLE = 16'hFF29;
  localparam logic [15:0] IDX_MONITOR_ENABLES_AND_REGULATION_BIT = 16'hFF2D;
  localparam logic [15:0] IDX_GROUP_B_SAMPLE_RATE_SELECT = 16'hFF33;
  localparam logic [15:0] IDX_GROUP_B_SAMPLE_ENABLE = 16'hFF34;
  localparam logic [15:0] IDX_GROUP_A_IRQ_MASK_REG = 16'hFFE3;
  localparam logic [15:0] IDX_GROUP_B_IRQ_MASK_REG = 16'hFFE4;
  localparam logic [15:0] IDX_GROUP_A_IRQ_FLAG_REG = 16'hFFF3;
  localparam logic [15:0] IDX_GROUP_B_IRQ_FLAG_REG = 16'hFFF4;

  // Field positions inside the mixed monitor register.
  localparam int MON_BIT_RECHARGE_ENABLE = 3;
  localparam int MON_BIT_LIMITER_ENABLE = 2;
  localparam int MON_BIT_LIMITER_STATUS = 1;
  localparam int MON_BIT_REGULATION_EXTRA = 0;

  // Position of the single mask bit and single flag bit in their registers.
  localparam int MASK_FLAG_BIT = 0;

  // Values after reset.
  localparam logic [3:0] RESET_NIBBLE = 4'h0;
  localparam logic RESET_BIT = 1'b0;
  // With no pin selected group A counts as matching.
  localparam logic RESET_GROUP_A_MATCH = 1'b1;

  // Timing: system clock and the fast and slow sampling clocks.
  localparam int CLK_HZ = 10_000_000;
  localparam int SAMPLE_FAST_HZ = 256;
  localparam int SAMPLE_SLOW_HZ = 32;
  // Cycles in one half period of the fast sampling clock, rounded down.
  localparam int FAST_HALF_CYCLES = CLK_HZ / (2 * SAMPLE_FAST_HZ);
  // Fast half periods in one slow half period.
  localparam int SLOW_PER_FAST_HALVES = SAMPLE_FAST_HZ / SAMPLE_SLOW_HZ;

  // Width of the synchronised pin bundle.
  localparam int PIN_BUNDLE_W = 14;

endpackage : input_port_pkg

// ===== rtl/pin_sync3.sv
// Three-stage synchroniser with agreement filter for the asynchronous input pins.
`timescale 1ns/100ps
module pin_sync3 #(
  parameter int W = 14
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] pins_async,
  output logic [W-1:0] pins_sync
);

  // All stages of the synchroniser held as one state word.
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_s;

  sync_s st;
  sync_s next_st;

  // The first stage feeds only the second; the filtered level moves only when stages two and three agree.
  always_comb begin
    next_st = st;
    next_st.s1 = pins_async;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.q = ((st.s2 ~^ st.s3) & st.s2) | ((st.s2 ^ st.s3) & st.q);
  end

  // Register the state; reset to a known low level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pins_sync = st.q;

endmodule : pin_sync3

// ===== rtl/sample_clock_gen.sv
// Divider that makes the fast and slow sampling clocks and their rising-edge pulses.
`timescale 1ns/100ps
module sample_clock_gen #(
  parameter int FAST_HALF = input_port_pkg::FAST_HALF_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic fast_rise,
  output logic slow_rise
);

  // Divider state: cycle counter, half-period counter and both clock levels.
  typedef struct packed {
    logic [15:0] cnt;
    logic [2:0] halves;
    logic fast_clk;
    logic slow_clk;
  } div_s;

  div_s st;
  div_s next_st;
  logic half_end;

  // The slow clock toggles on every eighth fast half period, so it stays locked to the fast one.
  always_comb begin
    next_st = st;
    half_end = (st.cnt == 16'(FAST_HALF - 1));
    if (half_end) begin
      next_st.cnt = '0;
      next_st.fast_clk = ~st.fast_clk;
      next_st.halves = st.halves + 3'h1;
      if (st.halves == 3'(input_port_pkg::SLOW_PER_FAST_HALVES - 1)) begin
        next_st.slow_clk = ~st.slow_clk;
      end
    end else begin
      next_st.cnt = st.cnt + 16'h0001;
    end
  end

  // Register the divider.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Pulses mark the cycle in which each clock is about to rise.
  assign fast_rise = half_end && !st.fast_clk;
  assign slow_rise = half_end && !st.slow_clk &&
                     (st.halves == 3'(input_port_pkg::SLOW_PER_FAST_HALVES - 1));

endmodule : sample_clock_gen

// ===== sim/input_port_interrupt_unit_bench.sv
// Self-checking bench: APB master tasks, a switch model and directed tests.
`timescale 1ns/100ps
module input_port_interrupt_unit_bench;
  localparam logic [15:0] ASEL = input_port_pkg::IDX_GROUP_A_IRQ_SELECT;
  localparam logic [15:0] ADAT = input_port_pkg::IDX_GROUP_A_INPUT_DATA;
  localparam logic [15:0] ACMP = input_port_pkg::IDX_GROUP_A_EDGE_COMPARE;
  localparam logic [15:0] BSEL = input_port_pkg::IDX_GROUP_B_IRQ_SELECT;
  localparam logic [15:0] BDAT = input_port_pkg::IDX_GROUP_B_INPUT_DATA;
  localparam logic [15:0] RNIB = input_port_pkg::IDX_REGULATION_INPUT_NIBBLE;
  localparam logic [15:0] MON = input_port_pkg::IDX_MONITOR_ENABLES_AND_REGULATION_BIT;
  localparam logic [15:0] BRATE = input_port_pkg::IDX_GROUP_B_SAMPLE_RATE_SELECT;
  localparam logic [15:0] BEN = input_port_pkg::IDX_GROUP_B_SAMPLE_ENABLE;
  localparam logic [15:0] AMSK = input_port_pkg::IDX_GROUP_A_IRQ_MASK_REG;
  localparam logic [15:0] BMSK = input_port_pkg::IDX_GROUP_B_IRQ_MASK_REG;
  localparam logic [15:0] AFLG = input_port_pkg::IDX_GROUP_A_IRQ_FLAG_REG;
  localparam logic [15:0] BFLG = input_port_pkg::IDX_GROUP_B_IRQ_FLAG_REG;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, rch_en, lim_en, irq, px, plim, slow;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pa, pb, pr;
  logic [13:0] pins;
  logic [15:0] rw_idx [0:7];
  logic [3:0] rw_keep [0:7];
  int failures, total_checks, cycles;

  switch_model sw (.pclk(pclk), .slow(slow), .want({plim, px, pr, pb, pa}), .pins(pins));
  // A short sampling divider keeps 256 Hz at 8 clocks and 32 Hz at 64.
  input_port_interrupt_unit #(.FAST_HALF(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .group_a_input_pins(pins[3:0]), .group_b_input_pins(pins[7:4]),
    .regulation_input_pins(pins[11:8]), .regulation_extra_pin(pins[12]), .limiter_level_status(pins[13]),
    .recharge_monitor_out_enable(rch_en), .limiter_monitor_out_enable(lim_en), .irq(irq));

  // Free-running system clock, 100 ns period.
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Hang guard: the whole run needs well under a thousand clocks.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the answer is taken at the rising edge where pready is seen high.
  // Only the hang guard ends a wait, so a stuck slave still reaches the closing report.
  task automatic xfer(input logic wr, input logic [17:0] addr, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    xfer(1'b1, {idx, 2'b00}, d);
  endtask : wr

  task automatic rdc(input logic [15:0] idx, input logic [31:0] exp);
    xfer(1'b0, {idx, 2'b00}, 32'h0);
    chk(rd, exp);
  endtask : rdc

  // Waits for the interrupt line up to n clocks, then compares it.
  task automatic wait_irq(input int n, input logic exp);
    for (int i = 0; i < n; i++) begin
      @(negedge pclk);
      if (irq === 1'b1) break;
    end
    chk({31'h0, irq}, {31'h0, exp});
    @(posedge pclk);
  endtask : wait_irq

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  initial begin
    {psel, penable, pwrite, paddr, pwdata, pa, pb, pr, px, plim, slow} = '0;
    presetn = 1'b0;
    rw_idx = '{ASEL, ACMP, BSEL, BRATE, BEN, AMSK, BMSK, MON};
    rw_keep = '{4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'h1, 4'h1, 4'hC};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values, then every writable bit set and read back.
    for (int i = 0; i < 8; i++) begin
      rdc(rw_idx[i], 32'h0);
      wr(rw_idx[i], 32'hFFFF_FFFF);
      rdc(rw_idx[i], {28'h0, rw_keep[i]});
      wr(rw_idx[i], 32'h0);
    end
    rdc(AFLG, 32'h0);
    rdc(BFLG, 32'h0);
    $display("test registers done");
    // Pin levels through slow switches, read-only writes and refused addresses.
    {pa, pb, pr, px, plim, slow} <= {4'h5, 4'hA, 4'h3, 3'b111};
    repeat (10) @(posedge pclk);
    rdc(ADAT, 32'h5);
    rdc(BDAT, 32'hA);
    rdc(RNIB, 32'h3);
    rdc(MON, 32'h3);
    wr(ADAT, 32'hA);
    rdc(ADAT, 32'h5);
    xfer(1'b0, {16'hFF23, 2'b00}, 32'h0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    xfer(1'b0, {ASEL, 2'b01}, 32'h0);
    chk({31'h0, err}, 32'h1);
    {pa, pb, pr, px, plim, slow} <= '0;
    repeat (10) @(posedge pclk);
    $display("test pins done");
    // Group A: rising compare, mask gating, clear, mismatch to mismatch.
    wr(ASEL, 32'h3);
    pa <= 4'h1;
    wait_irq(12, 1'b0);
    rdc(AFLG, 32'h1);
    wr(AMSK, 32'h1);
    wait_irq(1, 1'b1);
    wr(AFLG, 32'h0);
    rdc(AFLG, 32'h1);
    wr(AFLG, 32'h1);
    wait_irq(1, 1'b0);
    pa <= 4'h3;
    wait_irq(12, 1'b0);
    // Falling compare, then an unselected pin moves while the group matches.
    wr(ASEL, 32'h0);
    wr(ACMP, 32'h3);
    wr(ASEL, 32'h3);
    wait_irq(12, 1'b0);
    pa <= 4'hB;
    wait_irq(12, 1'b0);
    // Reselecting while the pin sits low fires again.
    pa <= 4'hA;
    wait_irq(12, 1'b1);
    wr(AFLG, 32'h1);
    wr(ASEL, 32'h0);
    wr(ASEL, 32'h3);
    wait_irq(12, 1'b1);
    wr(ASEL, 32'h0);
    wr(AFLG, 32'h1);
    wr(AMSK, 32'h0);
    $display("test group_a done");
    // Group B pin 0 sampled at 256 Hz: both edges, then sampler off.
    wr(BMSK, 32'h1);
    wr(BRATE, 32'h1);
    wr(BEN, 32'h1);
    wr(BSEL, 32'h1);
    pb <= 4'h1;
    wait_irq(20, 1'b1);
    rdc(BDAT, 32'h1);
    wr(BFLG, 32'h1);
    pb <= 4'h0;
    wait_irq(20, 1'b1);
    wr(BFLG, 32'h1);
    wr(BEN, 32'h0);
    pb <= 4'h1;
    wait_irq(100, 1'b0);
    // Group B pin 2: rising only when unsampled, both edges at 32 Hz.
    wr(BSEL, 32'h4);
    pb <= 4'h4;
    wait_irq(20, 1'b1);
    wr(BFLG, 32'h1);
    pb <= 4'h0;
    wait_irq(40, 1'b0);
    wr(BRATE, 32'h0);
    wr(BEN, 32'h4);
    pb <= 4'h4;
    wait_irq(100, 1'b1);
    pb <= 4'h0;
    wr(BFLG, 32'h1);
    rdc(BDAT, 32'h4);
    wait_irq(100, 1'b1);
    // Group B pin 3 unsampled, reselected while high.
    wr(BFLG, 32'h1);
    wr(BEN, 32'h0);
    wr(BSEL, 32'h0);
    pb <= 4'h8;
    repeat (10) @(posedge pclk);
    wr(BSEL, 32'h8);
    wait_irq(20, 1'b1);
    $display("test group_b done");
    test_done();
  end
endmodule : input_port_interrupt_unit_bench

// ===== sim/input_port_properties.sv
// Port-level checker for the input port unit, bound into the design.
`timescale 1ns/100ps
module input_port_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic recharge_monitor_out_enable,
  input wire logic limiter_monitor_out_enable,
  input wire logic irq
);
  localparam logic [17:0] FA = {input_port_pkg::IDX_GROUP_A_IRQ_FLAG_REG, 2'b00};
  localparam logic [17:0] FB = {input_port_pkg::IDX_GROUP_B_IRQ_FLAG_REG, 2'b00};
  int slot; // Writable register hit by paddr, or -1.
  logic mapped; // The address decodes to a register.
  logic [3:0] keep; // Bits of the hit register that hold state.
  logic [3:0] shadow [0:7]; // Last value written, so reads can be judged.

  // Decode the address the same way software sees the map.
  always_comb begin
    slot = -1;
    mapped = 1'b1;
    case (paddr)
      {input_port_pkg::IDX_GROUP_A_IRQ_SELECT, 2'b00}: slot = 0;
      {input_port_pkg::IDX_GROUP_A_EDGE_COMPARE, 2'b00}: slot = 1;
      {input_port_pkg::IDX_GROUP_B_IRQ_SELECT, 2'b00}: slot = 2;
      {input_port_pkg::IDX_GROUP_B_SAMPLE_RATE_SELECT, 2'b00}: slot = 3;
      {input_port_pkg::IDX_GROUP_B_SAMPLE_ENABLE, 2'b00}: slot = 4;
      {input_port_pkg::IDX_GROUP_A_IRQ_MASK_REG, 2'b00}: slot = 5;
      {input_port_pkg::IDX_GROUP_B_IRQ_MASK_REG, 2'b00}: slot = 6;
      {input_port_pkg::IDX_MONITOR_ENABLES_AND_REGULATION_BIT, 2'b00}: slot = 7;
      {input_port_pkg::IDX_GROUP_A_INPUT_DATA, 2'b00}, {input_port_pkg::IDX_GROUP_B_INPUT_DATA, 2'b00},
      {input_port_pkg::IDX_REGULATION_INPUT_NIBBLE, 2'b00}, FA, FB: slot = -1;
      default: mapped = 1'b0;
    endcase
    keep = (slot == 7) ? 4'hC : (slot > 4) ? 4'h1 : 4'hF;
  end

  // Shadow copy of every writable bit; a write lands only at the access edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) begin
        shadow[i] <= 4'h0;
      end
    end else if (psel && penable && pwrite && slot >= 0) begin
      shadow[slot] <= pwdata[3:0] & keep;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // A read of the group A flag set up while its request is the only one possible.
  sequence flag_a_setup;
    psel && !penable && !pwrite && paddr == FA && irq && shadow[5][0] && !shadow[6][0];
  endsequence
  sequence access_read;
    psel && penable && !pwrite;
  endsequence

  error_decode_a: assert property (psel && penable |-> pslverr == !mapped)
    else $error("error response does not follow the address map");
  error_phase_a: assert property (pslverr |-> psel && penable)
    else $error("error response outside an access phase");
  upper_zero_a: assert property (access_read |-> prdata[31:4] == 28'h0)
    else $error("read data has upper bits set");
  rw_readback_a: assert property (access_read ##0 slot >= 0 |-> (prdata[3:0] & keep) == shadow[slot])
    else $error("writable register reads back wrong value");
  unused_zero_a: assert property (access_read ##0 (slot > 4 && slot < 7 || paddr == FA || paddr == FB)
    |-> prdata[3:1] == 3'h0)
    else $error("unused mask or flag bit reads one");
  irq_masked_a: assert property (!shadow[5][0] && !shadow[6][0] |-> !irq)
    else $error("interrupt raised while both groups masked");
  flag_read_a: assert property (flag_a_setup |=> access_read ##0 prdata[0])
    else $error("pending group A request not shown in its flag");
  irq_reset_a: assert property ($rose(presetn) |-> !irq)
    else $error("interrupt high right after reset");
  monitor_out_a: assert property (recharge_monitor_out_enable == shadow[7][3]
    && limiter_monitor_out_enable == shadow[7][2])
    else $error("monitor enables differ from their register");
endmodule : input_port_properties

bind input_port_interrupt_unit input_port_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .recharge_monitor_out_enable(recharge_monitor_out_enable),
  .limiter_monitor_out_enable(limiter_monitor_out_enable), .irq(irq));

// ===== sim/switch_model.sv
// Model of the switches and level inputs that sit on the pin side of the unit.
`timescale 1ns/100ps
module switch_model (
  input wire logic pclk,
  input wire logic slow,
  input wire logic [13:0] want,
  output logic [13:0] pins
);
  logic [13:0] stage [0:2]; // Contact travel, so a slow switch lags its command.

  // Delay line; a slow switch settles three clocks late, a quick one after one clock.
  always_ff @(posedge pclk) begin
    stage[0] <= want;
    stage[1] <= stage[0];
    stage[2] <= stage[1];
  end
  assign pins = slow ? stage[2] : stage[0];
endmodule : switch_model
